// *** src/uncorrectable_severity.sv ***
// uncorrectable error severity bank with its mask and report path
// assumes event pulses and the register port share sys_clk_in
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ns

// Summary of operation
// - severity applies only to unmasked events
// - set severity bit reports fatal
// - clear severity bit reports non-fatal
// - bit zero sticky, resets zero, unused
// - link protocol severity bit 4, default one
// - surprise down severity bit 5, default one
// - poisoned packet severity bit 12, default zero
// - flow control severity bit 13, default one
// - bit 14 reads zero always
// - bit 15 reads zero always
// - unexpected completion bit 16, default zero
// - receiver overflow bit 17, default one
// - malformed packet bit 18, default one
// - end-to-end crc bit 19, default zero
// - unsupported request bit 20, default zero
// - masked events neither logged nor reported
module uncorrectable_severity
    import uncorrectable_severity_pkg::*;
(
    input wire logic sys_clk_in, // core clock, 100 MHz
    input wire logic rst_in, // hot or warm reset, sync, high
    input wire logic por_in, // fundamental power-on reset, sync, high
    input wire logic clk_en_in, // freezes state while low; rst_in and por_in still act
    input wire logic [uncorrectable_severity_pkg::ADDR_W-1:0] addr_in, // addr
    input wire logic [uncorrectable_severity_pkg::DATA_W-1:0] wdata_in, // data
    input wire logic wr_in, // write strobe
    input wire logic rd_in, // read strobe
    input wire logic [uncorrectable_severity_pkg::EVT_W-1:0] event_in, // pulses
    output logic [uncorrectable_severity_pkg::DATA_W-1:0] rdata_out, // data
    output logic fatal_out, // one-cycle fatal report pulse
    output logic nonfatal_out, // one-cycle non-fatal report pulse
    output logic [uncorrectable_severity_pkg::EVT_W-1:0] logged_out, // logged
    output logic irq_out // level interrupt
);
    import uncorrectable_severity_pkg::*;

    typedef struct packed {
        logic [DATA_W-1:0] sev;
        logic [DATA_W-1:0] mask;
        logic [DATA_W-1:0] rdata;
        logic fatal;
        logic nonfatal;
        logic [EVT_W-1:0] logged;
        logic [IRQ_W-1:0] irq_status;
        logic [IRQ_W-1:0] irq_enable;
        logic irq;
    } state_t;

    // register map seen from the port, byte addresses:
    //   severity word   - one stored bit per event class, sticky
    //   mask word       - same writable layout, sticky
    //   irq status      - bit 0 fatal seen, bit 1 non-fatal seen
    //   irq enable      - same layout as irq status
    //   irq clear       - write one to clear a status bit, reads zero
    // every other address reads zero and swallows writes, so software
    // probing the space never disturbs the bank
    //
    // severity word layout, bit by bit:
    //   0      stored and read back, never steers a report
    //   3:1    reserved, zero
    //   4      link protocol error class
    //   5      surprise down class
    //   11:6   reserved, zero
    //   12     poisoned packet class
    //   13     flow control protocol class
    //   14     completion time-out, always zero
    //   15     completer abort, always zero
    //   16     unexpected completion class
    //   17     receiver overflow class
    //   18     malformed packet class
    //   19     end-to-end crc class
    //   20     unsupported request class
    //   31:21  reserved, zero
    //
    // event lines follow the same numbering; a line on a reserved or
    // always-zero position is still taken and lands in the non-fatal
    // class, which is the safe choice for an unknown source
    //
    // report timing: an event seen at one rising edge shows its class
    // pulse and its log bit right after that edge; the interrupt
    // status bit is set at the same edge and the level output follows
    // from the same registered copy, so nothing lags a cycle behind

    // refuse package values the logic cannot serve
    if (EVT_W > DATA_W)
    begin
        $error("event lines wider than the register word");
    end
    if (IRQ_W != 2)
    begin
        $error("interrupt layout must hold exactly two bits");
    end
    if (UNSUPPORTED_REQ_SEV >= EVT_W)
    begin
        $error("highest severity field lies beyond the event lines");
    end
    if ((SEVERITY_RESET & ~SEVERITY_WMASK) != 32'h0000_0000)
    begin
        $error("severity reset sets a bit that cannot be stored");
    end
    if ((MASK_RESET & ~MASK_WMASK) != 32'h0000_0000)
    begin
        $error("mask reset sets a bit that cannot be stored");
    end

    state_t state_reg;
    state_t state_next;

    // masked write into a field, keeping read-only bits at zero
    function automatic logic [DATA_W-1:0] merge(
        input logic [DATA_W-1:0] old_val,
        input logic [DATA_W-1:0] new_val,
        input logic [DATA_W-1:0] wmask
    );
        merge = (new_val & wmask) | (old_val & ~wmask);
    endfunction

    // one stored bit of a register word, picked by its field position;
    // every severity field is read through here, so a field that moves
    // only has to change in the package
    function automatic logic field_bit(
        input logic [DATA_W-1:0] word,
        input int pos
    );
        field_bit = word[pos];
    endfunction

    // events that survive the mask; a masked line is dropped here and
    // so can neither reach the log nor raise a report
    function automatic logic [EVT_W-1:0] live_events(
        input logic [EVT_W-1:0] events,
        input logic [DATA_W-1:0] mask
    );
        live_events = events & ~mask[EVT_W-1:0];
    endfunction

    // split the live events into the two report classes; a class fires
    // when at least one live event carries that severity, so a cycle
    // with mixed severities raises both reports together
    function automatic logic [IRQ_W-1:0] classify(
        input logic [EVT_W-1:0] live,
        input logic [EVT_W-1:0] sev
    );
        classify = '0;
        classify[IRQ_FATAL] = |(live & sev);
        classify[IRQ_NONFATAL] = |(live & ~sev);
    endfunction

    // named view of the stored severity word, one signal per class
    logic link_protocol_err_sev; // fatal after power-on
    logic surprise_down_sev; // fatal after power-on
    logic poisoned_sev; // non-fatal after power-on
    logic flow_control_err_sev; // fatal after power-on
    logic completion_timeout_sev; // never stored, always zero
    logic completer_abort_sev; // never stored, always zero
    logic unexpected_cpl_sev; // non-fatal after power-on
    logic receive_overflow_sev; // fatal after power-on
    logic bad_format_packet_sev; // fatal after power-on
    logic end_to_end_crc_sev; // non-fatal after power-on
    logic unsupported_req_sev; // non-fatal after power-on

    // pick each class out of the stored word
    always_comb
    begin
        link_protocol_err_sev =
            field_bit(state_reg.sev, LINK_PROTOCOL_ERR_SEV);
        surprise_down_sev =
            field_bit(state_reg.sev, SURPRISE_DOWN_SEV);
        poisoned_sev =
            field_bit(state_reg.sev, POISONED_SEV);
        flow_control_err_sev =
            field_bit(state_reg.sev, FLOW_CONTROL_ERR_SEV);
        completion_timeout_sev =
            field_bit(state_reg.sev, COMPLETION_TIMEOUT_SEV);
        completer_abort_sev =
            field_bit(state_reg.sev, COMPLETER_ABORT_SEV);
        unexpected_cpl_sev =
            field_bit(state_reg.sev, UNEXPECTED_CPL_SEV);
        receive_overflow_sev =
            field_bit(state_reg.sev, RECEIVE_OVERFLOW_SEV);
        bad_format_packet_sev =
            field_bit(state_reg.sev, BAD_FORMAT_PACKET_SEV);
        end_to_end_crc_sev =
            field_bit(state_reg.sev, END_TO_END_CRC_SEV);
        unsupported_req_sev =
            field_bit(state_reg.sev, UNSUPPORTED_REQ_SEV);
    end

    logic [EVT_W-1:0] sev_class;

    // severity per event line; bit zero is stored but left out here,
    // so writing it can never turn a report fatal
    always_comb
    begin
        sev_class = '0;
        sev_class[LINK_PROTOCOL_ERR_SEV] = link_protocol_err_sev;
        sev_class[SURPRISE_DOWN_SEV] = surprise_down_sev;
        sev_class[POISONED_SEV] = poisoned_sev;
        sev_class[FLOW_CONTROL_ERR_SEV] = flow_control_err_sev;
        sev_class[COMPLETION_TIMEOUT_SEV] = completion_timeout_sev;
        sev_class[COMPLETER_ABORT_SEV] = completer_abort_sev;
        sev_class[UNEXPECTED_CPL_SEV] = unexpected_cpl_sev;
        sev_class[RECEIVE_OVERFLOW_SEV] = receive_overflow_sev;
        sev_class[BAD_FORMAT_PACKET_SEV] = bad_format_packet_sev;
        sev_class[END_TO_END_CRC_SEV] = end_to_end_crc_sev;
        sev_class[UNSUPPORTED_REQ_SEV] = unsupported_req_sev;
    end

    logic [EVT_W-1:0] unmasked;
    logic [IRQ_W-1:0] irq_set;

    // classification of the cycle's events
    always_comb
    begin
        unmasked = live_events(event_in, state_reg.mask);
        irq_set = classify(unmasked, sev_class);
    end

    // next state: register port, event report, interrupt bits
    always_comb
    begin
        state_next = state_reg;
        state_next.fatal = irq_set[IRQ_FATAL];
        state_next.nonfatal = irq_set[IRQ_NONFATAL];
        // masked events never reach the log
        state_next.logged = state_reg.logged | unmasked;
        state_next.rdata = '0;
        if (rd_in)
        begin
            case (addr_in)
                // bits 14, 15 and reserved ranges never stored
                SEVERITY_OFFSET: state_next.rdata = state_reg.sev;
                MASK_OFFSET: state_next.rdata = state_reg.mask;
                IRQ_STATUS_OFFSET:
                    state_next.rdata = {30'h0, state_reg.irq_status};
                IRQ_ENABLE_OFFSET:
                    state_next.rdata = {30'h0, state_reg.irq_enable};
                default: state_next.rdata = '0;
            endcase
        end
        if (wr_in)
        begin
            case (addr_in)
                SEVERITY_OFFSET:
                    state_next.sev = merge(state_reg.sev, wdata_in,
                        SEVERITY_WMASK);
                MASK_OFFSET:
                    state_next.mask = merge(state_reg.mask, wdata_in,
                        MASK_WMASK);
                IRQ_ENABLE_OFFSET:
                    state_next.irq_enable = wdata_in[IRQ_W-1:0];
                IRQ_CLEAR_OFFSET:
                    state_next.irq_status =
                        state_reg.irq_status & ~wdata_in[IRQ_W-1:0];
                default: ;
            endcase
        end
        // a new event wins over a clear in the same cycle
        state_next.irq_status = state_next.irq_status | irq_set;
        state_next.irq = |(state_next.irq_status & state_next.irq_enable);
    end

    // sticky fields survive rst_in; only por_in restores defaults
    always_ff @(posedge sys_clk_in)
    begin
        if (por_in)
        begin
            state_reg <= '0;
            state_reg.sev <= SEVERITY_RESET;
            state_reg.mask <= MASK_RESET;
        end
        else if (rst_in)
        begin
            // non-sticky state only
            state_reg.rdata <= '0;
            state_reg.fatal <= 1'b0;
            state_reg.nonfatal <= 1'b0;
            state_reg.irq_status <= '0;
            state_reg.irq_enable <= '0;
            state_reg.irq <= 1'b0;
        end
        else if (clk_en_in)
        begin
            state_reg <= state_next;
        end
    end

    // outputs straight from flops
    assign rdata_out = state_reg.rdata;
    assign fatal_out = state_reg.fatal;
    assign nonfatal_out = state_reg.nonfatal;
    assign logged_out = state_reg.logged;
    assign irq_out = state_reg.irq;
endmodule

// *** src/uncorrectable_severity_pkg.sv ***
// constants for the uncorrectable error severity register bank
// assumes a 32-bit configuration-space style register port
package uncorrectable_severity_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int EVT_W = 21;
    // register offsets
    localparam logic [11:0] SEVERITY_OFFSET = 12'h10c;
    localparam logic [11:0] MASK_OFFSET = 12'h108;
    localparam logic [11:0] IRQ_STATUS_OFFSET = 12'h200;
    localparam logic [11:0] IRQ_ENABLE_OFFSET = 12'h204;
    localparam logic [11:0] IRQ_CLEAR_OFFSET = 12'h208;
    // field positions
    localparam int UNUSED_BIT_ZERO = 0;
    localparam int LINK_PROTOCOL_ERR_SEV = 4;
    localparam int SURPRISE_DOWN_SEV = 5;
    localparam int POISONED_SEV = 12;
    localparam int FLOW_CONTROL_ERR_SEV = 13;
    localparam int COMPLETION_TIMEOUT_SEV = 14;
    localparam int COMPLETER_ABORT_SEV = 15;
    localparam int UNEXPECTED_CPL_SEV = 16;
    localparam int RECEIVE_OVERFLOW_SEV = 17;
    localparam int BAD_FORMAT_PACKET_SEV = 18;
    localparam int END_TO_END_CRC_SEV = 19;
    localparam int UNSUPPORTED_REQ_SEV = 20;
    // writable bits and reset values
    localparam logic [31:0] SEVERITY_WMASK = 32'h001f_3031;
    localparam logic [31:0] SEVERITY_RESET = 32'h0006_2030;
    localparam logic [31:0] MASK_WMASK = 32'h001f_3031;
    localparam logic [31:0] MASK_RESET = 32'h0000_0000;
    // interrupt status bit positions
    localparam int IRQ_FATAL = 0;
    localparam int IRQ_NONFATAL = 1;
    localparam int IRQ_W = 2;
endpackage

// *** sim/uncorrectable_severity_asserts.sv ***
// port checker: read path, error reports and the event log
// bound to the design top; one clock, either reset idles it
`timescale 1ns/1ns
module uncorrectable_severity_asserts (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic por_in,
    input wire logic clk_en_in,
    input wire logic [11:0] addr_in,
    input wire logic rd_in,
    input wire logic [20:0] event_in,
    input wire logic [31:0] rdata_out,
    input wire logic fatal_out,
    input wire logic nonfatal_out,
    input wire logic [20:0] logged_out,
    input wire logic irq_out
);
// por edge may clear the log, so its next cycle is skipped
default clocking cb @(posedge sys_clk_in); endclocking
default disable iff (rst_in || por_in);
property p_idle; clk_en_in && !rd_in |=> !rdata_out; endproperty
a_idle: assert property (p_idle) else $error("rdata not idle");
property p_rsv; rd_in && clk_en_in && addr_in == 12'h10c
    |=> !(rdata_out & 32'hffe0_c00e); endproperty
a_rsv: assert property (p_rsv) else $error("reserved set");
property p_hole; rd_in && clk_en_in && addr_in == 12'hffc
    |=> !rdata_out; endproperty
a_hole: assert property (p_hole) else $error("hole not zero");
property p_quiet; clk_en_in && !event_in
    |=> !fatal_out && !nonfatal_out; endproperty
a_quiet: assert property (p_quiet) else $error("report unprompted");
property p_keep; !$past(por_in) |-> !($past(logged_out) & ~logged_out);
endproperty
a_keep: assert property (p_keep) else $error("log bit lost");
property p_new; !(logged_out & ~$past(logged_out) & ~$past(event_in));
endproperty
a_new: assert property (p_new) else $error("log without event");
property p_rep; |(logged_out & ~$past(logged_out))
    |-> fatal_out || nonfatal_out; endproperty
a_rep: assert property (p_rep) else $error("logged, no report");
property p_both; fatal_out && nonfatal_out
    |-> $countones($past(event_in)) > 1; endproperty
a_both: assert property (p_both) else $error("double class");
c_fatal: cover property (fatal_out);
c_nonfatal: cover property (nonfatal_out);
c_irq: cover property (irq_out);
endmodule
bind uncorrectable_severity uncorrectable_severity_asserts
    uncorrectable_severity_asserts_i (.*);

// *** sim/uncorrectable_severity_test.sv ***
// bench: register port, event reports, resets and the interrupt
// drives the design top alone; checker comes in by bind
`timescale 1ns/1ns
module uncorrectable_severity_test;
logic sys_clk_in = 0, rst_in = 1, por_in = 1, clk_en_in = 1;
logic wr_in = 0, rd_in = 0, fatal_out, nonfatal_out, irq_out;
logic [11:0] addr_in = '0;
logic [31:0] wdata_in = '0, rdata_out;
logic [20:0] event_in = '0, logged_out;
int error_cnt = 0, n_checks = 0, cyc = 0;
uncorrectable_severity uncorrectable_severity_i (.*);
// clock, plus a hang guard well past the expected run
always #5 sys_clk_in = ~sys_clk_in;
always @(posedge sys_clk_in)
begin
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
        error_cnt++;
        report_and_stop();
    end
end
task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
        error_cnt++;
        $display("Error at %0t got %h exp %h", $time, g, e);
    end
endtask
// one-cycle strobes, released on the edge that takes them
task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    {wr_in, addr_in, wdata_in} <= {1'b1, a, d};
    @(posedge sys_clk_in);
    wr_in <= 1'b0;
endtask
task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge sys_clk_in);
    {rd_in, addr_in} <= {1'b1, a};
    @(posedge sys_clk_in);
    rd_in <= 1'b0;
    #1 chk(rdata_out, e);
endtask
// report pulses live one cycle, so look right after the edge
task automatic ev(input logic [20:0] b, input logic [1:0] e);
    @(posedge sys_clk_in);
    event_in <= b;
    @(posedge sys_clk_in);
    event_in <= '0;
    #1 chk({fatal_out, nonfatal_out}, e);
endtask
task automatic irq(input logic e);
    @(posedge sys_clk_in);
    #1 chk(irq_out, e);
endtask
task automatic t_regs;
    rd(12'h10c, 32'h0006_2030);
    wr(12'h10c, 32'hffff_ffff);
    rd(12'h10c, 32'h001f_3031);
    @(posedge sys_clk_in);
    rst_in <= 1'b1;
    @(posedge sys_clk_in);
    rst_in <= 1'b0;
    rd(12'h10c, 32'h001f_3031);
    rd(12'hffc, 32'h0);
    $display("regs done");
endtask
task automatic t_events;
    wr(12'h10c, 32'h10);
    ev(21'h10, 2'b10);
    ev(21'h1000, 2'b01);
    ev(21'h1010, 2'b11);
    wr(12'h108, 32'h20);
    ev(21'h20, 2'b00);
    chk(logged_out, 32'h1010);
    $display("events done");
endtask
task automatic t_irq;
    wr(12'h204, 32'h3);
    irq(1'b1);
    rd(12'h200, 32'h3);
    wr(12'h208, 32'h3);
    irq(1'b0);
    wr(12'h204, 32'h1);
    ev(21'h1000, 2'b01);
    irq(1'b0);
    $display("irq done");
endtask
// mask readback, irq from a fresh event, freeze, then both resets
task automatic t_misc;
    wr(12'h108, 32'hffff_ffff);
    rd(12'h108, 32'h001f_3031);
    wr(12'h108, 32'h0);
    wr(12'h208, 32'h3);
    wr(12'h204, 32'h3);
    irq(1'b0);
    ev(21'h20, 2'b01);
    irq(1'b1);
    ev(21'h1, 2'b01);
    @(posedge sys_clk_in);
    {clk_en_in, event_in} <= {1'b0, 21'h10};
    @(posedge sys_clk_in);
    {clk_en_in, event_in} <= {1'b1, 21'h0};
    #1 chk({fatal_out, nonfatal_out}, 2'b00);
    chk(logged_out, 32'h1031);
    @(posedge sys_clk_in);
    rst_in <= 1'b1;
    @(posedge sys_clk_in);
    rst_in <= 1'b0;
    #1 chk(logged_out, 32'h1031);
    @(posedge sys_clk_in);
    por_in <= 1'b1;
    @(posedge sys_clk_in);
    por_in <= 1'b0;
    #1 chk(logged_out, 32'h0);
    rd(12'h10c, 32'h0006_2030);
    $display("misc done");
endtask
task automatic report_and_stop;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
        $display("All tests passed");
    else
        $display("Some tests failed");
    $finish;
endtask
initial
begin
    repeat (12) @(posedge sys_clk_in);
    {rst_in, por_in} <= 2'b00;
    t_regs();
    t_events();
    t_irq();
    t_misc();
    report_and_stop();
end
endmodule
